// >>> dss_pkg.sv
// Shared constants and types of the dual-slope conversion sequencer
package dss_pkg;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STATE = 5'h04;
    localparam logic [4:0] OFF_RESULT = 5'h08;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h0c;
    localparam logic [4:0] OFF_IRQ_EN = 5'h10;
    localparam logic [4:0] OFF_IRQ_CLR = 5'h14;
    localparam logic [4:0] OFF_LOADED = 5'h18;
    localparam logic [4:0] OFF_CONV_CNT = 5'h1c;

    // Decoded register index, NONE for an unmapped address
    typedef enum logic [3:0] {
        REG_CTRL, REG_STATE, REG_RESULT, REG_IRQ_STAT,
        REG_IRQ_EN, REG_IRQ_CLR, REG_LOADED, REG_CONV_CNT, REG_NONE
    } dss_reg_t;

    // Control register fields and reset value
    localparam int CTRL_VAR_LSB = 0;
    localparam int CTRL_USED_LSB = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Resolution variants
    localparam logic [1:0] VAR_16 = 2'h0;
    localparam logic [1:0] VAR_14 = 2'h1;
    localparam logic [1:0] VAR_12 = 2'h2;

    // Interrupt bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVER = 1;
    localparam int IRQ_LOAD = 2;
    localparam int IRQ_W = 3;

    // Input integrate length of the 16-bit variant, 2^15 clocks
    localparam int INT_COUNT_16 = 32768;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Conversion phases
    typedef enum logic [1:0] {PH_AZ, PH_INT, PH_DEINT} dss_phase_t;

    // Latched result as it appears on the data lines
    typedef struct packed {
        logic overRange;
        logic polarity;
        logic [15:0] count;
    } dss_result_t;

    // Chip and byte disable lines, active low enables
    typedef struct packed {
        logic chipDisN;
        logic [2:0] byteDisN;
    } dss_disable_t;

endpackage

// >>> dss_sequencer.sv
// Dual-slope conversion sequencer with AXI4-Lite registers and gated result lines
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
module dss_sequencer #(
    parameter int INT_CYCLES = dss_pkg::INT_COUNT_16
) (
    input wire logic clock,
    input wire logic rstn,
    // AXI4-Lite slave
    input wire logic [4:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [4:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Converter pins
    input wire logic runHold,
    input wire logic comparatorHigh,
    input wire dss_pkg::dss_disable_t disablePins,
    input wire logic chipEnableLoadStrobe,
    output logic conversionStatusOutput,
    output logic autoZeroSwitch,
    output logic inputSwitch,
    output logic referenceSwitch,
    output logic referenceNegative,
    output dss_pkg::dss_result_t dataOut,
    output logic [2:0] dataOeN,
    output logic irq
);

    // Address decode shared by the read and write paths
    function automatic dss_pkg::dss_reg_t decodeReg(input logic [4:0] addr);
        case (addr)
            dss_pkg::OFF_CTRL: decodeReg = dss_pkg::REG_CTRL;
            dss_pkg::OFF_STATE: decodeReg = dss_pkg::REG_STATE;
            dss_pkg::OFF_RESULT: decodeReg = dss_pkg::REG_RESULT;
            dss_pkg::OFF_IRQ_STAT: decodeReg = dss_pkg::REG_IRQ_STAT;
            dss_pkg::OFF_IRQ_EN: decodeReg = dss_pkg::REG_IRQ_EN;
            dss_pkg::OFF_IRQ_CLR: decodeReg = dss_pkg::REG_IRQ_CLR;
            dss_pkg::OFF_LOADED: decodeReg = dss_pkg::REG_LOADED;
            dss_pkg::OFF_CONV_CNT: decodeReg = dss_pkg::REG_CONV_CNT;
            default: decodeReg = dss_pkg::REG_NONE;
        endcase
    endfunction

    localparam logic [16:0] INT_LEN_16 = 17'(INT_CYCLES);

    // Pin synchronisers: run/hold, comparator, four disables, load strobe
    logic [6:0] pinMeta_q;
    logic [6:0] pinSync_q;
    logic loadPrev_q;
    logic runS;
    logic compS;
    logic loadS;
    dss_pkg::dss_disable_t disS;

    // Registers
    logic [7:0] ctrl_q;
    logic [dss_pkg::IRQ_W-1:0] irqStat_q;
    logic [dss_pkg::IRQ_W-1:0] irqEn_q;
    dss_pkg::dss_result_t result_q;
    dss_pkg::dss_result_t loaded_q;
    logic [15:0] convCnt_q;

    // Sequencer state
    dss_pkg::dss_phase_t phase_q;
    logic [16:0] cnt_q;
    logic crossed_q;
    logic positive_q;
    logic [15:0] crossCount_q;
    logic latchPend_q;
    logic overPend_q;
    logic latchDone_q;
    logic statusFall_q;
    logic status_q;

    // AXI holding registers
    logic awHeld_q;
    logic [4:0] awAddr_q;
    logic wHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Derived lengths and events
    logic [1:0] variant;
    logic [16:0] intLen;
    logic [16:0] deintLen;
    logic crossEvt;
    logic deintEnd;
    logic cutShort;
    logic [2:0] groupEn;
    logic selected;
    logic loadEvt;
    logic wrDo;
    logic [dss_pkg::IRQ_W-1:0] irqSet;
    logic [dss_pkg::IRQ_W-1:0] irqClr;
    dss_pkg::dss_reg_t wrReg;
    dss_pkg::dss_disable_t disEff;

    // Two flops on every pin; only stage two is read by logic
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pinMeta_q <= 7'h0f;
            pinSync_q <= 7'h0f;
        end else begin
            pinMeta_q <= {chipEnableLoadStrobe, comparatorHigh, runHold, disablePins};
            pinSync_q <= pinMeta_q;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            loadPrev_q <= 1'b0;
        end else begin
            loadPrev_q <= loadS;
        end
    end

    assign disS = pinSync_q[3:0];
    assign runS = pinSync_q[4];
    assign compS = pinSync_q[5];
    assign loadS = pinSync_q[6];

    // Lengths scale by variant: 14-bit is a quarter, 12-bit a sixteenth
    assign variant = ctrl_q[dss_pkg::CTRL_VAR_LSB +: 2];
    always_comb begin
        case (variant)
            dss_pkg::VAR_14: intLen = INT_LEN_16 >> 2;
            dss_pkg::VAR_12: intLen = INT_LEN_16 >> 4;
            default: intLen = INT_LEN_16;
        endcase
    end
    assign deintLen = {intLen[15:0], 1'b0};

    // Crossing is the registered comparator leaving the input polarity
    assign crossEvt = (phase_q == dss_pkg::PH_DEINT) && !crossed_q
        && (compS != positive_q);
    assign deintEnd = (phase_q == dss_pkg::PH_DEINT) && (cnt_q == deintLen - 17'h00001);
    assign cutShort = (phase_q == dss_pkg::PH_DEINT) && crossed_q && !runS;

    // Phase sequencing; auto-zero lasts at least the input integrate length, longer while run/hold is low
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_q <= dss_pkg::PH_AZ;
            cnt_q <= 17'h00000;
            positive_q <= 1'b0;
        end else begin
            case (phase_q)
                dss_pkg::PH_AZ: begin
                    if (cnt_q >= intLen - 17'h00001) begin
                        if (runS) begin
                            phase_q <= dss_pkg::PH_INT;
                            cnt_q <= 17'h00000;
                        end
                    end else begin
                        cnt_q <= cnt_q + 17'h00001;
                    end
                end
                dss_pkg::PH_INT: begin
                    if (cnt_q == intLen - 17'h00001) begin
                        phase_q <= dss_pkg::PH_DEINT;
                        positive_q <= compS;
                        cnt_q <= 17'h00000;
                    end else begin
                        cnt_q <= cnt_q + 17'h00001;
                    end
                end
                dss_pkg::PH_DEINT: begin
                    // Full length keeps the cycle at four times intLen whatever the result
                    if (cutShort || deintEnd) begin
                        phase_q <= dss_pkg::PH_AZ;
                        cnt_q <= 17'h00000;
                    end else begin
                        cnt_q <= cnt_q + 17'h00001;
                    end
                end
                default: begin
                    phase_q <= dss_pkg::PH_AZ;
                    cnt_q <= 17'h00000;
                end
            endcase
        end
    end

    // Crossing capture: count of reference clocks up to the crossing
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            crossed_q <= 1'b0;
            crossCount_q <= 16'h0000;
        end else if (phase_q != dss_pkg::PH_DEINT) begin
            crossed_q <= 1'b0;
        end else if (crossEvt) begin
            crossed_q <= 1'b1;
            crossCount_q <= cnt_q[15:0];
        end
    end

    // Latch one clock after crossing or overload; status falls only once the
    // pins already show the new result, so its falling edge marks stable data
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            latchPend_q <= 1'b0;
            overPend_q <= 1'b0;
            latchDone_q <= 1'b0;
            statusFall_q <= 1'b0;
            result_q <= '0;
        end else begin
            latchPend_q <= crossEvt || (deintEnd && !crossed_q);
            overPend_q <= deintEnd && !crossed_q && !crossEvt;
            latchDone_q <= latchPend_q;
            statusFall_q <= latchDone_q;
            if (latchPend_q) begin
                result_q.overRange <= overPend_q;
                result_q.polarity <= positive_q;
                result_q.count <= overPend_q ? cnt_q[15:0] : crossCount_q;
            end
        end
    end

    // Status output: high from integrate start until after the latch
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_q <= 1'b0;
        end else if (phase_q == dss_pkg::PH_INT && cnt_q == 17'h00000) begin
            status_q <= 1'b1;
        end else if (statusFall_q) begin
            status_q <= 1'b0;
        end
    end

    // Analog switch drive; after the crossing the loop returns to auto-zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            autoZeroSwitch <= 1'b1;
            inputSwitch <= 1'b0;
            referenceSwitch <= 1'b0;
            referenceNegative <= 1'b0;
        end else begin
            autoZeroSwitch <= (phase_q == dss_pkg::PH_AZ) || crossed_q;
            inputSwitch <= phase_q == dss_pkg::PH_INT;
            referenceSwitch <= (phase_q == dss_pkg::PH_DEINT) && !crossed_q;
            referenceNegative <= positive_q;
        end
    end
    assign conversionStatusOutput = status_q;

    // Unused disable lines float high, so they read as disabled
    assign disEff.chipDisN = disS.chipDisN | ~ctrl_q[dss_pkg::CTRL_USED_LSB + 3];
    assign disEff.byteDisN = disS.byteDisN | ~ctrl_q[dss_pkg::CTRL_USED_LSB +: 3];

    // A group drives when chip and its own byte disable are both low
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gGroup
            assign groupEn[g] = !disEff.chipDisN && !disEff.byteDisN[g];
        end
    endgenerate
    assign selected = |groupEn;
    assign loadEvt = loadS && !loadPrev_q && selected;

    // Data lines come from flops; enables are low while driving
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dataOut <= '0;
            dataOeN <= 3'h7;
        end else begin
            dataOut <= result_q;
            dataOeN <= ~groupEn;
        end
    end

    // Load strobe snapshot and conversion counter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            loaded_q <= '0;
            convCnt_q <= 16'h0000;
        end else begin
            if (loadEvt) begin
                loaded_q <= result_q;
            end
            if (latchPend_q) begin
                convCnt_q <= convCnt_q + 16'h0001;
            end
        end
    end

    // AXI write: address and data taken in either order, then one response
    assign awready = !awHeld_q && !bvalid_q;
    assign wready = !wHeld_q && !bvalid_q;
    assign wrDo = awHeld_q && wHeld_q;
    assign wrReg = decodeReg(awAddr_q);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 5'h00;
            wHeld_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= dss_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (wrDo) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wrReg == dss_pkg::REG_NONE) ? dss_pkg::RESP_SLVERR
                    : dss_pkg::RESP_OKAY;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // Writable fields all sit in byte lane 0
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= dss_pkg::CTRL_RESET;
            irqEn_q <= '0;
        end else if (wrDo && wStrb_q[0]) begin
            if (wrReg == dss_pkg::REG_CTRL) begin
                ctrl_q <= wData_q[7:0];
            end
            if (wrReg == dss_pkg::REG_IRQ_EN) begin
                irqEn_q <= wData_q[dss_pkg::IRQ_W-1:0];
            end
        end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle
    assign irqSet = {loadEvt, latchPend_q && overPend_q, latchPend_q};
    assign irqClr = (wrDo && wStrb_q[0] && wrReg == dss_pkg::REG_IRQ_CLR)
        ? wData_q[dss_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irqStat_q <= '0;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
        end
    end
    assign irq = |(irqStat_q & irqEn_q);

    // AXI read: one cycle answer, unmapped addresses get SLVERR and zero
    assign arready = !rvalid_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= dss_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= dss_pkg::RESP_OKAY;
            case (decodeReg(araddr))
                dss_pkg::REG_CTRL: rdata_q <= {24'h000000, ctrl_q};
                dss_pkg::REG_STATE: rdata_q <= {27'h0000000, crossed_q, status_q,
                    runS, phase_q};
                dss_pkg::REG_RESULT: rdata_q <= {14'h0000, result_q};
                dss_pkg::REG_IRQ_STAT: rdata_q <= {29'h00000000, irqStat_q};
                dss_pkg::REG_IRQ_EN: rdata_q <= {29'h00000000, irqEn_q};
                dss_pkg::REG_LOADED: rdata_q <= {14'h0000, loaded_q};
                dss_pkg::REG_CONV_CNT: rdata_q <= {16'h0000, convCnt_q};
                dss_pkg::REG_IRQ_CLR: rdata_q <= 32'h00000000; // Write-only
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= dss_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

endmodule

// >>> dss_host_model.sv
// Host-side model: run/hold drive and the integrator comparator
module dss_host_model (
    input wire logic clock,
    input wire logic referenceSwitch,
    input wire logic [1:0] runMode,
    input wire logic polarity,
    input wire logic [15:0] crossAt,
    output logic runHold,
    output logic comparatorHigh
);
    timeunit 1ns;
    timeprecision 1ps;
    int refCnt = 0;
    initial runHold = 1'b0;
    initial comparatorHigh = 1'b1;
    // Mode 2 toggles every clock, standing in for a tie to the clock output
    always @(posedge clock) runHold <= runMode == 2'h2 ? !runHold : runMode[0];
    // Integrator crosses zero crossAt clocks into the reference phase
    always @(posedge clock) begin
        refCnt <= referenceSwitch ? refCnt + 1 : 0;
        comparatorHigh <= referenceSwitch && refCnt >= crossAt ? !polarity : polarity;
    end
endmodule

// >>> dss_sequencer_props.sv
// Checks of phase timing and output gating at the sequencer ports
module dss_sequencer_props #(
    parameter int INT_CYCLES = 64
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic runHold,
    input wire dss_pkg::dss_disable_t disablePins,
    input wire logic conversionStatusOutput,
    input wire logic autoZeroSwitch,
    input wire logic inputSwitch,
    input wire logic referenceSwitch,
    input wire dss_pkg::dss_result_t dataOut,
    input wire logic [2:0] dataOeN
);
    timeunit 1ns;
    timeprecision 1ps;
    // Latest restart after a cut reference phase with run/hold toggling
    localparam int CUT_MAX = INT_CYCLES + 8;
    int intLen_q, refLen_q, azLen_q, cycLen_q;
    logic lowSeen_q;
    logic startNow;
    logic stat;
    assign startNow = inputSwitch && intLen_q == 0;
    assign stat = conversionStatusOutput;
    // Phase lengths; lowSeen marks a conversion that saw any hold request
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            intLen_q <= 0;
            refLen_q <= 0;
            azLen_q <= 0;
            cycLen_q <= 0;
            lowSeen_q <= 1'b1; // History before reset is unknown
        end else begin
            intLen_q <= inputSwitch ? intLen_q + 1 : 0;
            refLen_q <= referenceSwitch ? refLen_q + 1 : 0;
            azLen_q <= autoZeroSwitch ? azLen_q + 1 : 0;
            cycLen_q <= startNow ? 1 : cycLen_q + 1;
            lowSeen_q <= startNow ? !runHold : lowSeen_q || !runHold;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // Run/hold toggling just after the crossing, before status falls
    sequence holdToggleAfterCross;
        (autoZeroSwitch && stat && !runHold) ##1 runHold ##1 !runHold;
    endsequence
    chk_run_period: assert property (startNow && !lowSeen_q |-> cycLen_q == 4 * INT_CYCLES)
        else $error("conversion period wrong");
    chk_integrate_len: assert property ($fell(inputSwitch) |-> intLen_q == INT_CYCLES)
        else $error("integrate length wrong");
    chk_reference_max: assert property (referenceSwitch |-> refLen_q < 2 * INT_CYCLES)
        else $error("reference phase too long");
    chk_hold_cut: assert property (holdToggleAfterCross |-> ##[1:CUT_MAX] $rose(inputSwitch))
        else $error("reference phase not cut short");
    chk_az_minimum: assert property ($fell(autoZeroSwitch) |-> azLen_q >= INT_CYCLES)
        else $error("auto-zero too short");
    chk_status_span: assert property (inputSwitch |-> stat)
        else $error("status low in integrate");
    chk_latch_status: assert property ($changed(dataOut) |-> stat ##1 !stat)
        else $error("status not falling after latch");
    chk_chip_gate: assert property (disablePins.chipDisN [*4] |-> dataOeN == 3'h7)
        else $error("group driven while chip disabled");
    chk_byte_gate: assert property (disablePins.byteDisN[0] [*4] |-> dataOeN[0])
        else $error("low group driven while disabled");
    cover property ($rose(dataOut.overRange));
    cover property (startNow && !lowSeen_q);
    cover property ($fell(autoZeroSwitch) && azLen_q > 2 * INT_CYCLES);
endmodule

bind dss_sequencer dss_sequencer_props #(.INT_CYCLES(INT_CYCLES)) props (
    .clock(clock), .rstn(rstn), .runHold(runHold), .disablePins(disablePins),
    .conversionStatusOutput(conversionStatusOutput), .autoZeroSwitch(autoZeroSwitch),
    .inputSwitch(inputSwitch), .referenceSwitch(referenceSwitch), .dataOut(dataOut),
    .dataOeN(dataOeN)
);

// >>> dss_sequencer_test.sv
// Self-checking bench of the conversion sequencer with a host model on its pins
`define CHECK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module dss_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 64;
    localparam int LIMIT = 20000;
    int failures = 0, compares = 0, cycles = 0;
    logic clock = 1'b0, rstn = 1'b0, strobe = 1'b0, pol = 1'b1;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, runMode = 2'h1;
    logic [1:0] lastResp = 2'h0;
    logic [15:0] crossAt = 16'h0014;
    logic runHold, cmpHigh, status, azSw, inSw, refSw, refNeg;
    dss_pkg::dss_disable_t disablePins = 4'hf;
    dss_pkg::dss_result_t dataOut;
    logic [2:0] dataOeN;

    dss_sequencer #(.INT_CYCLES(N)) DUT (
        .clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .runHold(runHold), .comparatorHigh(cmpHigh), .disablePins(disablePins),
        .chipEnableLoadStrobe(strobe), .conversionStatusOutput(status),
        .autoZeroSwitch(azSw), .inputSwitch(inSw), .referenceSwitch(refSw),
        .referenceNegative(refNeg), .dataOut(dataOut), .dataOeN(dataOeN), .irq(irq)
    );
    dss_host_model HOST (
        .clock(clock), .referenceSwitch(refSw), .runMode(runMode), .polarity(pol),
        .crossAt(crossAt), .runHold(runHold), .comparatorHigh(cmpHigh)
    );

    always #12.5 clock = !clock;
    // Cycle count doubles as the hang limit
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Address and data offered together; bready held until the response
    task automatic axiWrite(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        lastResp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [4:0] a, output logic [31:0] d);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        lastResp = rresp;
        rready <= 1'b0;
    endtask
    // Returns the cycle at which status rose, once the result has latched
    task automatic waitConv(output int stamp);
        do @(posedge clock); while (status !== 1'b1);
        stamp = cycles;
        do @(posedge clock); while (status !== 1'b0);
    endtask
    task automatic pulse();
        strobe <= 1'b1;
        repeat (4) @(posedge clock);
        strobe <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic t_run();
        int s1, s2;
        logic [15:0] c1;
        waitConv(s1);
        c1 = dataOut.count;
        crossAt <= 16'h000f; // Earlier than the crossing already passed
        waitConv(s2);
        `CHECK("period", 4 * N, s2 - s1)
        `CHECK("count step", 16'h0005, c1 - dataOut.count)
        `CHECK("polarity", 1'b1, dataOut.polarity)
        `CHECK("reference sign", 1'b1, refNeg)
    endtask
    task automatic t_over();
        int s;
        crossAt <= 16'hffff;
        waitConv(s);
        axiRead(dss_pkg::OFF_RESULT, rd);
        `CHECK("over-range", {14'h0, 2'h3, 16'h0000}, rd)
        axiRead(dss_pkg::OFF_IRQ_STAT, rd);
        `CHECK("over flag", 1'b1, rd[dss_pkg::IRQ_OVER])
        pol <= 1'b0;
        crossAt <= 16'h0014;
        waitConv(s);
        `CHECK("negative", 2'h0, {dataOut.overRange, dataOut.polarity})
        `CHECK("reference sign", 1'b0, refNeg)
        pol <= 1'b1;
    endtask
    task automatic t_hold();
        int s;
        do @(posedge clock); while (inSw !== 1'b1);
        runMode <= 2'h0;
        do @(posedge clock); while (refSw !== 1'b1);
        s = cycles;
        do @(posedge clock); while (refSw !== 1'b0);
        `CHECK("cut short", 1'b1, cycles - s < 30)
        axiRead(dss_pkg::OFF_STATE, rd);
        `CHECK("phase after cut", 2'(dss_pkg::PH_AZ), rd[1:0])
        repeat (3 * N) @(posedge clock);
        `CHECK("parked", 3'h4, {azSw, inSw, status})
        runMode <= 2'h1;
        s = cycles;
        do @(posedge clock); while (inSw !== 1'b1);
        // Host flop, two sync flops, phase flop, switch flop, then our look
        `CHECK("restart", 6, cycles - s)
    endtask
    task automatic t_fast();
        int s;
        runMode <= 2'h2;
        do @(posedge clock); while (refSw !== 1'b1);
        do @(posedge clock); while (refSw !== 1'b0);
        s = cycles;
        do @(posedge clock); while (inSw !== 1'b1);
        `CHECK("min auto-zero", 1'b1, cycles - s >= N && cycles - s <= N + 4)
        runMode <= 2'h0;
        repeat (4 * N) @(posedge clock);
    endtask
    task automatic t_load();
        axiRead(dss_pkg::OFF_CTRL, rd);
        `CHECK("ctrl reset", {24'h0, dss_pkg::CTRL_RESET}, rd)
        disablePins <= 4'h0;
        repeat (6) @(posedge clock);
        `CHECK("unused off", 3'h7, dataOeN)
        axiWrite(dss_pkg::OFF_IRQ_CLR, 32'h7);
        axiWrite(dss_pkg::OFF_IRQ_EN, 32'h4);
        axiWrite(dss_pkg::OFF_CTRL, 32'h70); // Chip line left undriven
        pulse();
        axiRead(dss_pkg::OFF_IRQ_STAT, rd);
        `CHECK("unselected load", 32'h0, rd)
        axiRead(dss_pkg::OFF_LOADED, rd);
        `CHECK("no snapshot", 32'h0, rd)
        axiWrite(dss_pkg::OFF_CTRL, 32'hf0);
        repeat (6) @(posedge clock);
        `CHECK("driving", 3'h0, dataOeN)
        pulse();
        `CHECK("load irq", 1'b1, irq)
        axiRead(dss_pkg::OFF_LOADED, rd);
        `CHECK("snapshot", {14'h0, dataOut}, rd)
        axiWrite(dss_pkg::OFF_IRQ_EN, 32'h0);
        `CHECK("masked", 1'b0, irq)
        axiWrite(dss_pkg::OFF_IRQ_CLR, 32'h4);
        axiRead(dss_pkg::OFF_IRQ_STAT, rd);
        `CHECK("cleared", 32'h0, rd)
        `CHECK("read okay", dss_pkg::RESP_OKAY, lastResp)
        axiRead(5'h02, rd);
        `CHECK("bad read", {dss_pkg::RESP_SLVERR, 32'h0}, {lastResp, rd})
        axiWrite(5'h02, 32'h1);
        `CHECK("bad write", dss_pkg::RESP_SLVERR, lastResp)
    endtask

    // Reset for four cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        t_run();
        t_over();
        t_hold();
        t_fast();
        t_load();
        end_of_test();
    end
endmodule
